// ---- hw/line_circuit_state_control.sv ----
/*
   Control logic of a subscriber line interface: control word capture,
   two-tier decode into line mode, switch and test path settings, and
   the two supervision outputs.
   Assumes every pin input is asynchronous to clk; the analog side reads
   the decoded outputs as levels.
*/
`default_nettype none

module line_circuit_state_control
#(
   parameter bit GND_ACTIVE_HIGH = 1'b1 // Ground present drives output high
)
(
   input  wire logic                    clk,                // 100 MHz clock
   input  wire logic                    rst,                // Async reset, high
   input  wire logic                    code_bit_0,         // Control word bit 0
   input  wire logic                    code_bit_1,         // Control word bit 1
   input  wire logic                    code_bit_2,         // Control word bit 2
   input  wire logic                    tier_select_bit,    // 0 primary, 1 secondary
   input  wire logic                    latch_strobe,       // Capture on fall
   input  wire logic                    line_reset_n,       // Line reset pin, low
   input  wire logic                    loop_closed,        // Loop closure detector
   input  wire logic                    ring_trip,          // Ring trip detector
   input  wire logic                    ground_detect_flag, // Tip/ring ground seen
   output var  line_ctrl_pkg::line_mode_t line_mode,        // Line circuit mode
   output var  line_ctrl_pkg::switch_t  switches,           // Break/access switches
   output var  line_ctrl_pkg::test_t    test_path,          // Test path settings
   output logic                         loop_status_n,      // Low = off-hook/trip
   output logic                         ground_detect_out   // Ground indication
);
   import line_ctrl_pkg::*;

   // ****************************************
   // Switch settings per primary code
   // ****************************************
   // Ring access closes only with both breaks open, so the ringing
   // source never meets a driven tip or ring
   localparam switch_t SW_FEED      = '{1'b1, 1'b1, 1'b0};
   localparam switch_t SW_RINGING   = '{1'b0, 1'b0, 1'b1};
   localparam switch_t SW_TIP_ONLY  = '{1'b1, 1'b0, 1'b0};
   localparam switch_t SW_RING_ONLY = '{1'b0, 1'b1, 1'b0};
   localparam switch_t SW_CAL_OPEN  = '{1'b0, 1'b0, 1'b0};

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      pins_t      sync1;
      pins_t      sync2;
      logic       strobe_prev;
      line_mode_t mode;
      switch_t    sw;
      test_t      test;
      logic       status_n;
      logic       gnd_out;
   } state_t;

   // Sync stages leave reset showing the line reset asserted, which only
   // repeats the reset state for two cycles; strobe history starts high
   // like an idle strobe pin, so leaving reset with the strobe pin high is never taken as a fall
   localparam state_t STATE_RST = '{
      PINS_RST,
      PINS_RST,
      1'b1,
      MODE_RST,
      SW_ALL_OFF,
      TEST_IDLE,
      1'b1,
      ~GND_ACTIVE_HIGH
   };

   state_t state_q;
   state_t state_d;
   pins_t  pins_raw;

   assign pins_raw.code        = {tier_select_bit, code_bit_2, code_bit_1, code_bit_0};
   assign pins_raw.strobe      = latch_strobe;
   assign pins_raw.reset_n     = line_reset_n;
   assign pins_raw.loop_closed = loop_closed;
   assign pins_raw.ring_trip   = ring_trip;
   assign pins_raw.ground_seen = ground_detect_flag;

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      logic              capture;
      logic              line_held;
      logic              tier_sec;
      logic [CODE_W-1:0] low_code;
      state_d   = state_q;
      capture   = 1'b0;
      line_held = ~state_q.sync2.reset_n;
      tier_sec  = state_q.sync2.code[TIER_POS];
      low_code  = state_q.sync2.code[CODE_W-1:0];

      // ****************************************
      // Synchronisers and strobe edge
      // ****************************************
      // Second stage is the only reader of the first
      state_d.sync1       = pins_raw;
      state_d.sync2       = state_q.sync1;
      state_d.strobe_prev = state_q.sync2.strobe;

      // Capture once per falling strobe; a held-low strobe re-reads nothing
      capture = state_q.strobe_prev & ~state_q.sync2.strobe;

      // ****************************************
      // Control word decode
      // ****************************************
      if (line_held)
      begin
         // Pin reset wins over word and strobe
         state_d.mode = MODE_DISC;
         state_d.sw   = SW_ALL_OFF;
         // Test path is cleared too, so no stale source outlives a line reset
         state_d.test = TEST_IDLE;
      end
      else if (capture)
      begin
         if (!tier_sec)
         begin
            // Test path is left alone by every primary code
            case (low_code)
               PRI_SCAN:
               begin
                  state_d.mode = MODE_SCAN;
                  state_d.sw   = SW_FEED;
               end
               PRI_FWD:
               begin
                  state_d.mode = MODE_FWD;
                  state_d.sw   = SW_FEED;
               end
               PRI_REV:
               begin
                  state_d.mode = MODE_REV;
                  state_d.sw   = SW_FEED;
               end
               PRI_TR_AMP:
               begin
                  // Calibration setting: both breaks open, mode kept
                  state_d.sw = SW_CAL_OPEN;
               end
               PRI_RING:
               begin
                  state_d.mode = MODE_RING;
                  state_d.sw   = SW_RINGING;
               end
               PRI_T_AMP:
               begin
                  state_d.sw = SW_TIP_ONLY;
               end
               PRI_R_AMP:
               begin
                  state_d.sw = SW_RING_ONLY;
               end
               PRI_DISC:
               begin
                  state_d.mode = MODE_DISC;
                  state_d.sw   = SW_ALL_OFF;
               end
               default:
               begin
                  state_d.mode = state_q.mode;
               end
            endcase
         end
         else
         begin
            // Mode and switches are not touched here
            case (low_code)
               SEC_TR_V:
               begin
                  state_d.test = '{1'b1, 1'b1, SRC_TR_V};
               end
               SEC_T_V:
               begin
                  state_d.test = '{1'b1, 1'b1, SRC_T_V};
               end
               SEC_R_V:
               begin
                  state_d.test = '{1'b1, 1'b1, SRC_R_V};
               end
               SEC_XIMP_I:
               begin
                  state_d.test = '{1'b1, 1'b1, SRC_XIMP_I};
               end
               SEC_REF:
               begin
                  state_d.test = '{1'b1, 1'b0, SRC_REF};
               end
               SEC_AC_I:
               begin
                  state_d.test = '{1'b1, 1'b1, SRC_AC_I};
               end
               SEC_UNUSED:
               begin
                  // Undefined code: safest reading is no change
                  state_d.test = state_q.test;
               end
               SEC_OFF:
               begin
                  state_d.test = TEST_IDLE;
               end
               default:
               begin
                  state_d.test = state_q.test;
               end
            endcase
         end
      end

      // ****************************************
      // Supervision
      // ****************************************
      // Supervision runs every cycle from the synchronised detectors
      case (state_q.mode)
         MODE_DISC:
         begin
            state_d.status_n = 1'b1;
         end
         MODE_RING:
         begin
            state_d.status_n = ~state_q.sync2.ring_trip;
         end
         MODE_SCAN:
         begin
            // Only loop closure stays awake in scan
            state_d.status_n = ~state_q.sync2.loop_closed;
         end
         MODE_FWD:
         begin
            state_d.status_n = ~state_q.sync2.loop_closed;
         end
         MODE_REV:
         begin
            state_d.status_n = ~state_q.sync2.loop_closed;
         end
         default:
         begin
            state_d.status_n = 1'b1;
         end
      endcase

      // Polarity left open; parameter picks the sense
      if (GND_ACTIVE_HIGH)
      begin
         state_d.gnd_out = state_q.sync2.ground_seen;
      end
      else
      begin
         state_d.gnd_out = ~state_q.sync2.ground_seen;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= STATE_RST;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Each output is a field of the state register; no logic after it
   assign line_mode         = state_q.mode;
   assign switches          = state_q.sw;
   assign test_path         = state_q.test;
   assign loop_status_n     = state_q.status_n;
   assign ground_detect_out = state_q.gnd_out;

endmodule
`default_nettype wire

// ---- hw/line_ctrl_pkg.sv ----
/*
   Shared types and constants for the line circuit state control block.
   Assumes one 100 MHz clock and pins that are asynchronous to it.
*/
`default_nettype none
package line_ctrl_pkg;

   // ****************************************
   // Control word layout
   // ****************************************
   localparam int TIER_POS = 3;
   localparam int CODE_W   = 3;

   // ****************************************
   // Primary codes
   // ****************************************
   localparam logic [2:0] PRI_SCAN   = 3'h0;
   localparam logic [2:0] PRI_FWD    = 3'h1;
   localparam logic [2:0] PRI_REV    = 3'h2;
   localparam logic [2:0] PRI_TR_AMP = 3'h3;
   localparam logic [2:0] PRI_RING   = 3'h4;
   localparam logic [2:0] PRI_T_AMP  = 3'h5;
   localparam logic [2:0] PRI_R_AMP  = 3'h6;
   localparam logic [2:0] PRI_DISC   = 3'h7;

   // ****************************************
   // Secondary codes
   // ****************************************
   localparam logic [2:0] SEC_TR_V   = 3'h0;
   localparam logic [2:0] SEC_T_V    = 3'h1;
   localparam logic [2:0] SEC_R_V    = 3'h2;
   localparam logic [2:0] SEC_XIMP_I = 3'h3;
   localparam logic [2:0] SEC_REF    = 3'h4;
   localparam logic [2:0] SEC_AC_I   = 3'h5;
   localparam logic [2:0] SEC_UNUSED = 3'h6;
   localparam logic [2:0] SEC_OFF    = 3'h7;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      MODE_SCAN,
      MODE_FWD,
      MODE_REV,
      MODE_RING,
      MODE_DISC
   } line_mode_t;

   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_TR_V,
      SRC_T_V,
      SRC_R_V,
      SRC_XIMP_I,
      SRC_REF,
      SRC_AC_I
   } test_src_t;

   typedef struct packed {
      logic tip_break;   // 1 = closed
      logic ring_break;  // 1 = closed
      logic ring_access; // 1 = closed
   } switch_t;

   typedef struct packed {
      logic       level_en;
      logic       signal_en;
      test_src_t  source;
   } test_t;

   typedef struct packed {
      logic [3:0] code;
      logic       strobe;
      logic       reset_n;
      logic       loop_closed;
      logic       ring_trip;
      logic       ground_seen;
   } pins_t;

   // ****************************************
   // Reset values
   // ****************************************
   localparam switch_t    SW_ALL_OFF = '{1'b0, 1'b0, 1'b0};
   localparam test_t      TEST_IDLE  = '{1'b0, 1'b0, SRC_NONE};
   localparam line_mode_t MODE_RST   = MODE_DISC;
   localparam pins_t      PINS_RST   = '{4'hf, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage
`default_nettype wire

// ---- tb/line_ctrl_props.sv ----
/* Concurrent checks on the line control block ports.
   Assumes one clock domain with asynchronous active-high rst. */
`default_nettype none
module line_ctrl_props
   import line_ctrl_pkg::*;
#(
   parameter bit GND_ACTIVE_HIGH = 1'b1 // Ground polarity as in design
)
(
   input wire logic       clk,                // Clock
   input wire logic       rst,                // Async reset
   input wire logic       code_bit_0,         // Word bit 0
   input wire logic       code_bit_1,         // Word bit 1
   input wire logic       code_bit_2,         // Word bit 2
   input wire logic       tier_select_bit,    // Word bit 3
   input wire logic       latch_strobe,       // Strobe
   input wire logic       line_reset_n,       // Line reset
   input wire logic       loop_closed,        // Loop detector
   input wire logic       ring_trip,          // Trip detector
   input wire logic       ground_detect_flag, // Ground detector
   input wire line_mode_t line_mode,          // Mode
   input wire switch_t    switches,           // Switches
   input wire test_t      test_path,          // Test path
   input wire logic       loop_status_n,      // Loop status
   input wire logic       ground_detect_out   // Ground output
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Six quiet cycles cover the two sync stages plus the decode register
   sequence s_pri;
      (!tier_select_bit && line_reset_n)[*6];
   endsequence
   sequence s_sec;
      (tier_select_bit && line_reset_n)[*6];
   endsequence

   AST_PRI_KEEP_TEST: assert property (s_pri |-> $stable(test_path))
      else $error("primary word changed test path");
   AST_SEC_KEEP_PRI: assert property (s_sec |-> $stable({line_mode, switches}))
      else $error("secondary word changed mode or switches");
   AST_HOLD_HIGH: assert property ((latch_strobe && line_reset_n)[*6]
      |-> $stable({line_mode, switches, test_path}))
      else $error("state changed without strobe fall");
   AST_REF_LEVEL: assert property (test_path.source == SRC_REF
      |-> test_path.level_en && !test_path.signal_en)
      else $error("reference source with wrong enables");
   AST_TEST_BOTH: assert property (test_path.source inside
      {SRC_TR_V, SRC_T_V, SRC_R_V, SRC_XIMP_I, SRC_AC_I}
      |-> test_path.level_en && test_path.signal_en)
      else $error("measurement source without both enables");
   AST_OFF_IDLE: assert property (!test_path.level_en |-> test_path == TEST_IDLE)
      else $error("test off not idle");
   AST_LINE_RST: assert property ($fell(line_reset_n)
      |-> ##[1:4] (line_mode == MODE_DISC && switches == SW_ALL_OFF))
      else $error("line reset did not disconnect");
   AST_DISC_STATUS: assert property ((line_mode == MODE_DISC)[*2] |-> loop_status_n)
      else $error("status low in disconnect");
   AST_RING_STATUS: assert property ((line_mode == MODE_RING && $stable(ring_trip))[*5]
      |-> loop_status_n == !ring_trip)
      else $error("ring status wrong");
   AST_LOOP_STATUS: assert property ((line_mode inside {MODE_SCAN, MODE_FWD, MODE_REV}
      && $stable(loop_closed))[*5] |-> loop_status_n == !loop_closed)
      else $error("loop status wrong");
   AST_GND: assert property ($stable(ground_detect_flag)[*5]
      |-> ground_detect_out == (ground_detect_flag ~^ GND_ACTIVE_HIGH))
      else $error("ground output wrong");
endmodule

bind line_circuit_state_control line_ctrl_props #(.GND_ACTIVE_HIGH(GND_ACTIVE_HIGH))
   line_ctrl_props_i (.clk(clk), .rst(rst), .code_bit_0(code_bit_0),
   .code_bit_1(code_bit_1), .code_bit_2(code_bit_2), .tier_select_bit(tier_select_bit),
   .latch_strobe(latch_strobe), .line_reset_n(line_reset_n), .loop_closed(loop_closed),
   .ring_trip(ring_trip), .ground_detect_flag(ground_detect_flag), .line_mode(line_mode),
   .switches(switches), .test_path(test_path), .loop_status_n(loop_status_n),
   .ground_detect_out(ground_detect_out));
`default_nettype wire

// ---- tb/line_ctl_model.sv ----
/* Controller model driving the control word and latch strobe.
   Assumes send is called at a falling clock edge. */
`default_nettype none
module line_ctl_model
(
   input  wire logic clk,    // Bench clock
   output logic [3:0] word,   // Tier bit and code bits
   output logic       strobe  // Latch strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      word = 4'hf;
      strobe = 1'b1;
   end

   // Word settles three cycles before the fall; bad flips it while held low
   task automatic send(input logic [3:0] w, input bit bad);
      word = w;
      repeat (3) @(negedge clk);
      strobe = 1'b0;
      repeat (2) @(negedge clk);
      if (bad)
         word = ~w;
      repeat (2) @(negedge clk);
      strobe = 1'b1;
      repeat (3) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ---- tb/line_circuit_state_control_tb.sv ----
/* Self-checking bench for the line control block.
   Assumes the controller model and the bound checker. */
`default_nettype none
module line_circuit_state_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import line_ctrl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, line_reset_n = 1'b1, loop_closed = 1'b0;
   logic ring_trip = 1'b0, ground_detect_flag = 1'b0, latch_strobe, loop_status_n;
   logic [3:0] word;
   logic ground_detect_out;
   line_mode_t line_mode;
   switch_t switches;
   test_t test_path;
   int num_errors = 0, checks_done = 0;
   localparam line_mode_t MODE_TAB [8] = '{MODE_SCAN, MODE_FWD, MODE_REV, MODE_DISC,
      MODE_RING, MODE_DISC, MODE_DISC, MODE_DISC};
   localparam logic [2:0] SW_TAB [8] = '{3'h6, 3'h6, 3'h6, 3'h0, 3'h1, 3'h4, 3'h2, 3'h0};
   localparam test_src_t SRC_TAB [8] = '{SRC_TR_V, SRC_T_V, SRC_R_V, SRC_XIMP_I,
      SRC_REF, SRC_AC_I, SRC_NONE, SRC_NONE};

   initial
   begin
      forever #5 clk = ~clk;
   end

   line_ctl_model ctl_i (.clk(clk), .word(word), .strobe(latch_strobe));
   line_circuit_state_control line_circuit_state_control_i (.clk(clk), .rst(rst),
      .code_bit_0(word[0]), .code_bit_1(word[1]), .code_bit_2(word[2]),
      .tier_select_bit(word[3]), .latch_strobe(latch_strobe), .line_reset_n(line_reset_n),
      .loop_closed(loop_closed), .ring_trip(ring_trip),
      .ground_detect_flag(ground_detect_flag), .line_mode(line_mode),
      .switches(switches), .test_path(test_path), .loop_status_n(loop_status_n),
      .ground_detect_out(ground_detect_out));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic settle;
      repeat (6) @(negedge clk);
   endtask

   task automatic chk_idle(input line_mode_t m);
      chk(8'(line_mode), 8'(m));
      chk(8'(test_path), 8'(TEST_IDLE));
   endtask

   task automatic pri_all;
      line_mode_t m;
      m = MODE_DISC;
      chk(8'({loop_status_n, ground_detect_out, switches}), 8'h10);
      chk_idle(MODE_DISC);
      for (int i = 0; i < 8; i++)
      begin
         ctl_i.send({1'b0, 3'(i)}, 1'b0);
         if (!(i inside {3, 5, 6}))
            m = MODE_TAB[i];
         chk(8'(switches), 8'(SW_TAB[i]));
         chk_idle(m);
      end
   endtask

   task automatic sec_all;
      test_t t;
      t = TEST_IDLE;
      ctl_i.send(4'h1, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         ctl_i.send({1'b1, 3'(i)}, 1'b0);
         if (i == 4)
            t = '{1'b1, 1'b0, SRC_REF};
         else if (i == 7)
            t = TEST_IDLE;
         else if (i != 6)
            t = '{1'b1, 1'b1, SRC_TAB[i]};
         chk(8'(test_path), 8'(t));
         if (i == 6)
            chk(8'(test_path), 8'({2'h3, SRC_AC_I}));
         chk(8'({line_mode, switches}), 8'({MODE_FWD, 3'h6}));
      end
   endtask

   task automatic persist;
      logic [3:0] seq [4] = '{4'h2, 4'h0, 4'h4, 4'h7};
      ctl_i.send(4'h8, 1'b0);
      foreach (seq[i])
      begin
         ctl_i.send(seq[i], 1'b0);
         chk(8'(test_path), 8'({2'h3, SRC_TR_V}));
      end
      ctl_i.send(4'hf, 1'b0);
      chk_idle(MODE_DISC);
   endtask

   task automatic hold_and_status;
      ctl_i.send(4'h2, 1'b1);
      chk(8'({line_mode, switches}), 8'({MODE_REV, 3'h6}));
      loop_closed = 1'b1;
      settle();
      chk(8'(loop_status_n), 8'h0);
      ctl_i.send(4'h4, 1'b0);
      chk(8'(loop_status_n), 8'h1);
      ring_trip = 1'b1;
      settle();
      chk(8'(loop_status_n), 8'h0);
      ctl_i.send(4'h7, 1'b0);
      chk(8'(loop_status_n), 8'h1);
      ground_detect_flag = 1'b1;
      settle();
      chk(8'(ground_detect_out), 8'h1);
      ground_detect_flag = 1'b0;
      ring_trip = 1'b0;
      loop_closed = 1'b0;
   endtask

   task automatic line_rst;
      ctl_i.send(4'h1, 1'b0);
      ctl_i.send(4'h9, 1'b0);
      line_reset_n = 1'b0;
      // A capture during line reset is lost
      ctl_i.send(4'h2, 1'b0);
      chk(8'(switches), 8'(SW_ALL_OFF));
      chk_idle(MODE_DISC);
      line_reset_n = 1'b1;
      settle();
      chk_idle(MODE_DISC);
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end

   initial
   begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
      pri_all();
      sec_all();
      persist();
      hold_and_status();
      line_rst();
      tally_and_finish();
   end
endmodule
`default_nettype wire
